// File: hw/vmux_pkg.sv
// Package with register map, field layouts and types of the input mux control.
package vmux_pkg;

    // ------------------------------------------------------------------
    // Register indices and address width
    // ------------------------------------------------------------------
    localparam logic [11:0] SEL_IDX = 12'h103;
    localparam logic [11:0] GAIN_IDX = 12'h110;
    localparam logic [11:0] FILT_IDX = 12'h111;
    localparam logic [11:0] CONV_IDX = 12'h112;
    localparam logic [11:0] CLK_IDX = 12'h113;
    localparam logic [11:0] TRIM_IDX = 12'h114;
    localparam logic [11:0] STAT_IDX = 12'h115;
    localparam int ADDR_W = 14;

    // ------------------------------------------------------------------
    // Field layouts and reset values
    // ------------------------------------------------------------------
    localparam int CH1_LSB = 0;
    localparam int CH2_LSB = 4;
    localparam int CH3_LSB = 6;
    localparam logic [7:0] SEL_RST = 8'h00;
    localparam logic [1:0] CH2_NONE = 2'h3;
    localparam logic [7:0] GAIN_RST = 8'h00;
    localparam logic [1:0] BW_FULL = 2'h0;
    localparam logic [1:0] BW_HALF = 2'h1;
    localparam logic [1:0] BW_BYPASS = 2'h2;
    localparam logic [7:0] PIX_MULT = 8'h08;
    localparam logic [8:0] AUX_384 = 9'h180;
    localparam logic [8:0] AUX_256 = 9'h100;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [15:0] ALT_DIV_RST = 16'h0004;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        aux_mult_384,
        aux_mult_256,
        aux_free_run,
        aux_mult_custom
    } aux_mode_t;

    typedef struct packed {
        logic [8:0] first_channel_source_select;
        logic [3:0] second_channel_source_select;
        logic [2:0] third_channel_source_select;
    } source_sel_t;

    typedef struct packed {
        logic [1:0] ch1_bw;
        logic [1:0] ch2_bw;
        logic [1:0] ch3_bw;
    } filter_sel_t;

endpackage

// File: hw/chan_decode.sv
// Decoder from a select field to a one-hot input enable vector.
`timescale 1ns/1ps
module chan_decode #(
    parameter int SEL_W = 3,
    parameter int OUT_W = 9,
    parameter int BASE = 0,
    parameter int LIMIT = 8
) (
    input wire logic [SEL_W-1:0] sel,
    output logic [OUT_W-1:0] onehot
);

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    // Bit 0 means unconnected; bit k+1 means the k-th candidate input.
    always_comb begin
        onehot = '0;
        if (int'(sel) < LIMIT) begin
            onehot[int'(sel) + 1] = 1'b1;
        end else begin
            onehot[0] = 1'b1;
        end
    end

endmodule

// File: hw/video_input_mux_control.sv
// Top level of the video input mux control with its AXI4-Lite slave.
// Operation
// - First channel field selects inputs one to eight.
// - Second channel field: inputs four to six, none.
// - Third channel field: inputs seven, eight, none.
// - Converter one fixed; converter two shared or alternating.
// - Gain follows loop unless manual gain enabled.
// - Per channel filter: full, half or bypass.
// - Decoder clock multiple of pixel rate, trimmed.
// - Auxiliary clock locked multiple or free running.
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module video_input_mux_control
    import vmux_pkg::*;
#(
    parameter int ALT_W = 16
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] loop_gain,
    input wire logic [15:0] field_rate_error,
    output source_sel_t source_sel,
    output logic second_converter_from_third,
    output logic second_converter_power_down,
    output logic [7:0] amplifier_gain,
    output filter_sel_t filter_sel,
    output logic [7:0] decoder_pll_mult,
    output logic [15:0] decoder_pll_frac,
    output aux_mode_t aux_pll_mode,
    output logic [8:0] aux_pll_mult
);

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [7:0] video_input_select_reg;
    logic [8:0] gain_ctrl_reg;
    logic [5:0] filter_ctrl_reg;
    logic [17:0] conv_ctrl_reg;
    logic [18:0] clk_ctrl_reg;
    logic [15:0] trim_base_reg;
    logic [ALT_W-1:0] alt_cnt_reg;
    logic alt_phase_reg;
    logic [31:0] wdata_reg;
    logic [ADDR_W-1:0] awaddr_reg;
    logic aw_held_reg;
    logic w_held_reg;
    logic wstrb0_reg;

    // ------------------------------------------------------------------
    // Write channel handshake
    // ------------------------------------------------------------------
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire aw_have = aw_held_reg || aw_take;
    wire w_have = w_held_reg || w_take;
    wire do_write = aw_have && w_have && !s_axi_bvalid;
    wire [ADDR_W-1:0] wr_addr = aw_held_reg ? awaddr_reg : s_axi_awaddr;
    wire [31:0] wr_data = w_held_reg ? wdata_reg : s_axi_wdata;
    wire [11:0] wr_idx = wr_addr[13:2];
    wire wr_lane0 = w_held_reg ? wstrb0_reg : s_axi_wstrb[0];
    wire wr_sel = do_write && wr_idx == SEL_IDX && wr_lane0;
    wire wr_gain = do_write && wr_idx == GAIN_IDX;
    wire wr_filt = do_write && wr_idx == FILT_IDX && wr_lane0;
    wire wr_conv = do_write && wr_idx == CONV_IDX;
    wire wr_clk = do_write && wr_idx == CLK_IDX;
    wire wr_trim = do_write && wr_idx == TRIM_IDX;
    wire wr_hit = wr_idx == SEL_IDX || wr_idx == GAIN_IDX ||
        wr_idx == FILT_IDX || wr_idx == CONV_IDX ||
        wr_idx == CLK_IDX || wr_idx == TRIM_IDX;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            w_held_reg <= 1'b0;
            awaddr_reg <= '0;
            wdata_reg <= '0;
            wstrb0_reg <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_reg <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_reg <= s_axi_wdata;
                wstrb0_reg <= s_axi_wstrb[0];
            end
            aw_held_reg <= aw_have && !do_write;
            w_held_reg <= w_have && !do_write;
            s_axi_awready <= !aw_have && !s_axi_awready;
            s_axi_wready <= !w_have && !s_axi_wready;
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            video_input_select_reg <= SEL_RST;
            gain_ctrl_reg <= {1'b0, GAIN_RST};
            filter_ctrl_reg <= {BW_FULL, BW_FULL, BW_FULL};
            conv_ctrl_reg <= {ALT_DIV_RST, 2'b00};
            clk_ctrl_reg <= {AUX_384, 2'b00, PIX_MULT};
            trim_base_reg <= '0;
        end else begin
            if (wr_sel) begin
                video_input_select_reg <= wr_data[7:0];
            end
            if (wr_gain) begin
                gain_ctrl_reg <= wr_data[8:0];
            end
            if (wr_filt) begin
                filter_ctrl_reg <= wr_data[5:0];
            end
            if (wr_conv) begin
                conv_ctrl_reg <= wr_data[17:0];
            end
            if (wr_clk) begin
                clk_ctrl_reg <= wr_data[18:0];
            end
            if (wr_trim) begin
                trim_base_reg <= wr_data[15:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel source decode
    // ------------------------------------------------------------------
    logic [8:0] ch1_dec;
    logic [3:0] ch2_dec;
    logic [2:0] ch3_dec;

    chan_decode #(.SEL_W(3), .OUT_W(9), .LIMIT(8)) u_ch1 (
        .sel(video_input_select_reg[CH1_LSB +: 3]),
        .onehot(ch1_dec)
    );
    chan_decode #(.SEL_W(2), .OUT_W(4), .LIMIT(3)) u_ch2 (
        .sel(video_input_select_reg[CH2_LSB +: 2]),
        .onehot(ch2_dec)
    );
    chan_decode #(.SEL_W(2), .OUT_W(3), .LIMIT(2)) u_ch3 (
        .sel(video_input_select_reg[CH3_LSB +: 2]),
        .onehot(ch3_dec)
    );

    // ------------------------------------------------------------------
    // Converter sharing, gain, clocks
    // ------------------------------------------------------------------
    wire alt_en = conv_ctrl_reg[0];
    wire static_third = conv_ctrl_reg[1];
    wire [ALT_W-1:0] alt_div = ALT_W'(conv_ctrl_reg[17:2]);
    wire alt_wrap = alt_cnt_reg >= alt_div;
    wire ch2_none = video_input_select_reg[CH2_LSB +: 2] == CH2_NONE;
    wire ch3_none = video_input_select_reg[CH3_LSB + 1];
    wire manual_gain = gain_ctrl_reg[8];
    wire [1:0] aux_sel = clk_ctrl_reg[9:8];
    wire [15:0] trimmed = trim_base_reg + field_rate_error;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alt_cnt_reg <= '0;
            alt_phase_reg <= 1'b0;
            source_sel <= '0;
            second_converter_from_third <= 1'b0;
            second_converter_power_down <= 1'b0;
            amplifier_gain <= GAIN_RST;
            filter_sel <= '0;
            decoder_pll_mult <= PIX_MULT;
            decoder_pll_frac <= '0;
            aux_pll_mode <= aux_mult_384;
            aux_pll_mult <= AUX_384;
        end else begin
            alt_cnt_reg <= alt_wrap ? '0 : alt_cnt_reg + 1'b1;
            if (alt_wrap) begin
                alt_phase_reg <= !alt_phase_reg;
            end
            source_sel <= '{ch1_dec, ch2_dec, ch3_dec};
            second_converter_from_third <= alt_en ? alt_phase_reg :
                static_third;
            second_converter_power_down <= ch2_none && ch3_none;
            amplifier_gain <= manual_gain ? gain_ctrl_reg[7:0] :
                loop_gain;
            filter_sel <= filter_ctrl_reg;
            decoder_pll_mult <= clk_ctrl_reg[7:0];
            decoder_pll_frac <= trimmed;
            aux_pll_mode <= aux_mode_t'(aux_sel);
            case (aux_mode_t'(aux_sel))
                aux_mult_384: aux_pll_mult <= AUX_384;
                aux_mult_256: aux_pll_mult <= AUX_256;
                default: aux_pll_mult <= clk_ctrl_reg[18:10];
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    wire [11:0] rd_idx = s_axi_araddr[13:2];
    wire [31:0] rd_word =
        rd_idx == SEL_IDX ? {24'h0, video_input_select_reg} :
        rd_idx == GAIN_IDX ? {23'h0, gain_ctrl_reg} :
        rd_idx == FILT_IDX ? {26'h0, filter_ctrl_reg} :
        rd_idx == CONV_IDX ? {14'h0, conv_ctrl_reg} :
        rd_idx == CLK_IDX ? {13'h0, clk_ctrl_reg} :
        rd_idx == TRIM_IDX ? {16'h0, trim_base_reg} :
        {8'h0, amplifier_gain, decoder_pll_frac};
    wire rd_hit = rd_idx == SEL_IDX || rd_idx == GAIN_IDX ||
        rd_idx == FILT_IDX || rd_idx == CONV_IDX || rd_idx == CLK_IDX ||
        rd_idx == TRIM_IDX || rd_idx == STAT_IDX;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
                s_axi_arvalid;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_hit ? rd_word : 32'h0;
                s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

// File: sim/vmux_checker.sv
// Concurrent checks on the ports of the video input mux control.
`timescale 1ns/1ps
module vmux_checker
    import vmux_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire source_sel_t source_sel,
    input wire logic second_converter_power_down,
    input wire logic [7:0] decoder_pll_mult,
    input wire logic [8:0] aux_pll_mult
);
    // ------------------------------------------------------------------
    // Helper decode
    // ------------------------------------------------------------------
    wire wr_sel = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
        s_axi_wready && s_axi_wstrb[0] && s_axi_awaddr == {SEL_IDX, 2'h0};
    wire both_none = source_sel.second_channel_source_select[0] &&
        source_sel.third_channel_source_select[0];
    logic [7:0] sel_data_reg;

    always_ff @(posedge aclk) begin
        if (wr_sel) begin
            sel_data_reg <= s_axi_wdata[7:0];
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    first_hot_a: assert property (
        aresetn && $past(aresetn) |->
        $onehot(source_sel.first_channel_source_select))
        else $error("first select not one-hot");
    first_dec_a: assert property (
        wr_sel |-> ##2 source_sel.first_channel_source_select ==
        (9'h002 << sel_data_reg[2:0]))
        else $error("first select decode wrong");
    second_dec_a: assert property (
        wr_sel |-> ##2 source_sel.second_channel_source_select ==
        ((sel_data_reg[5:4] == 2'h3) ? 4'h1 :
        (4'h2 << sel_data_reg[5:4])))
        else $error("second select decode wrong");
    third_dec_a: assert property (
        wr_sel |-> ##2 source_sel.third_channel_source_select ==
        (sel_data_reg[7] ? 3'h1 : (3'h2 << sel_data_reg[6])))
        else $error("third select decode wrong");
    conv_down_a: assert property (
        $rose(both_none) |-> ##[0:1] second_converter_power_down)
        else $error("second converter not powered down");
    power_match_a: assert property (
        second_converter_power_down == both_none)
        else $error("power down does not match selects");
    pll_reset_a: assert property (
        !$past(aresetn) |-> decoder_pll_mult == PIX_MULT)
        else $error("decoder multiple wrong after reset");
    aux_reset_a: assert property (
        !$past(aresetn) |-> aux_pll_mult == AUX_384)
        else $error("aux multiple wrong after reset");
    bresp_hold_a: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write response dropped early");
    rdata_hold_a: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
        $stable(s_axi_rdata))
        else $error("read response dropped early");
    sel_write_c: cover property (wr_sel);
    none_c: cover property ($rose(both_none));
    read_c: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind video_input_mux_control vmux_checker i_chk (.*);

// File: sim/test_video_input_mux_control.sv
// Register level testbench of the video input mux control.
`timescale 1ns/1ps
module test_video_input_mux_control;
    import vmux_pkg::*;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [7:0] loop_gain = 8'h33, amplifier_gain, decoder_pll_mult;
    logic [15:0] field_rate_error = 16'h0010, decoder_pll_frac;
    source_sel_t source_sel;
    filter_sel_t filter_sel;
    aux_mode_t aux_pll_mode;
    logic second_converter_from_third, second_converter_power_down;
    logic [8:0] aux_pll_mult;
    int n_mismatch = 0;
    int tests_run = 0;

    always #5 aclk = ~aclk;

    video_input_mux_control i_dut (.*);

    // ------------------------------------------------------------------
    // Bus tasks and checks
    // ------------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] idx, input logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'h0};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        repeat (3) @(posedge aclk);
    endtask

    task automatic rd(input logic [11:0] idx, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
    endtask

    task automatic finish_test;
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial begin
        logic [7:0] d;
        logic [31:0] q;
        logic [1:0] r;
        logic b;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        chk(source_sel, {9'h002, 4'h2, 3'h2});
        chk(decoder_pll_mult, PIX_MULT);
        chk(aux_pll_mult, AUX_384);
        rd(SEL_IDX, q, r);
        chk(q, SEL_RST);
        $display("Reset test done.");
        for (int i = 0; i < 8; i++) begin
            d = {i[2:1], i[1:0], 1'h0, i[2:0]};
            wr(SEL_IDX, d, r);
            chk(r, RESP_OKAY);
            chk(source_sel.first_channel_source_select,
                9'h002 << i[2:0]);
            chk(source_sel.second_channel_source_select,
                (i[1:0] == 2'h3) ? 4'h1 : 4'h2 << i[1:0]);
            chk(source_sel.third_channel_source_select,
                i[2] ? 3'h1 : 3'h2 << i[1]);
            chk(second_converter_power_down, i == 7);
            rd(SEL_IDX, q, r);
            chk(q, d);
        end
        wr(SEL_IDX, 32'h0000_00b2, r);
        chk(source_sel, {9'h008, 4'h1, 3'h1});
        chk(second_converter_power_down, 1'h1);
        wr(SEL_IDX, 32'h0000_0090, r);
        chk(source_sel, {9'h002, 4'h4, 3'h1});
        chk(second_converter_power_down, 1'h0);
        wr(12'h100, 32'h0000_00ff, r);
        chk(r, RESP_SLVERR);
        rd(12'h100, q, r);
        chk(r, RESP_SLVERR);
        chk(q, 32'h0);
        s_axi_wstrb <= 4'he;
        wr(SEL_IDX, 32'h0000_00f7, r);
        s_axi_wstrb <= 4'hf;
        rd(SEL_IDX, q, r);
        chk(q, 32'h0000_0090);
        $display("Select test done.");
        wr(GAIN_IDX, 32'h0000_015a, r);
        chk(amplifier_gain, 8'h5a);
        wr(GAIN_IDX, 32'h0000_00a5, r);
        chk(amplifier_gain, 8'h33);
        loop_gain <= 8'h44;
        repeat (3) @(posedge aclk);
        chk(amplifier_gain, 8'h44);
        for (int v = 0; v < 3; v++) begin
            wr(FILT_IDX, {v[1:0], v[1:0], v[1:0]}, r);
            chk(filter_sel, {v[1:0], v[1:0], v[1:0]});
        end
        wr(CONV_IDX, 32'h0000_0012, r);
        chk(second_converter_from_third, 1'h1);
        wr(CONV_IDX, 32'h0000_0010, r);
        chk(second_converter_from_third, 1'h0);
        wr(CONV_IDX, 32'h0000_0011, r);
        b = second_converter_from_third;
        repeat (5) @(posedge aclk);
        chk(second_converter_from_third, !b);
        repeat (5) @(posedge aclk);
        chk(second_converter_from_third, b);
        for (int m = 0; m < 3; m++) begin
            wr(CLK_IDX, {m[1:0], 8'h08}, r);
            chk(aux_pll_mode, m[1:0]);
            if (m < 2) chk(aux_pll_mult, m[0] ? AUX_256 : AUX_384);
        end
        wr(CLK_IDX, {9'h0c0, 2'h3, 8'h10}, r);
        chk(aux_pll_mode, 2'h3);
        chk(aux_pll_mult, 9'h0c0);
        chk(decoder_pll_mult, 8'h10);
        wr(TRIM_IDX, 32'h0000_1000, r);
        chk(decoder_pll_frac, 16'h1010);
        field_rate_error <= 16'h0020;
        repeat (2) @(posedge aclk);
        chk(decoder_pll_frac, 16'h1020);
        rd(STAT_IDX, q, r);
        chk(r, RESP_OKAY);
        chk(q, 32'h0044_1020);
        $display("Control test done.");
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (2) @(posedge aclk);
        chk(source_sel, {9'h002, 4'h2, 3'h2});
        chk(decoder_pll_mult, PIX_MULT);
        chk(aux_pll_mult, AUX_384);
        rd(SEL_IDX, q, r);
        chk(q, SEL_RST);
        $display("Second reset test done.");
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge aclk);
        n_mismatch++;
        finish_test();
    end
endmodule
